// file: core/els_line_mux.sv
// Sixteen line source multiplexers, one selector each
`timescale 1ns/1ps
`default_nettype none
module els_line_mux
	import els_pkg::*;
(
	// Selector and pin side
	els_mux_if.mux mux_if
);
	always_comb
	begin
		for (int i = 0; i < LINE_COUNT; i++)
		begin
			// Reserved codes select no pin and give a quiet low line
			if (mux_if.sel[i] <= SEL_CODE_MAX)
				mux_if.lines[i] = mux_if.pins[mux_if.sel[i][2:0]][i];
			else
				mux_if.lines[i] = 1'b0;
		end
	end
endmodule : els_line_mux
`default_nettype wire

// file: core/els_top.sv
// External line source select registers, line routing and address-valid pin release
`timescale 1ns/1ps
`default_nettype none
module els_top
	import els_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// Port pins, index [port][pin]
	input wire logic [PORT_COUNT-1:0][LINE_COUNT-1:0] i_port_pins,
	// External interrupt lines
	output logic [LINE_COUNT-1:0] o_ext_line,
	// Memory controller address-valid strobe and its pin
	input wire logic i_addr_valid_strobe,
	output logic o_addr_valid_pin,
	output logic o_addr_valid_pin_oe,
	output logic o_addr_valid_pin_release
);
	els_state_s state_q;
	els_state_s state_d;
	els_mux_if mux_if ();

	els_line_mux u_mux (
		.mux_if(mux_if.mux)
	);

	assign mux_if.pins = state_q.pins_sync;
	assign mux_if.sel = state_q.sel;

	always_comb
	begin
		state_d = state_q;
		// Pins are asynchronous; two stages before the multiplexer sees them
		state_d.pins_meta = i_port_pins;
		state_d.pins_sync = state_q.pins_meta;
		state_d.ext_line = mux_if.lines;
		state_d.rdata = RDATA_RESET;
		if (i_wr)
		begin
			case (i_addr)
				OFF_SEL_0_3: state_d.sel[3:0] = i_wdata[SEL_FIELD_W-1:0];
				OFF_SEL_4_7: state_d.sel[7:4] = i_wdata[SEL_FIELD_W-1:0];
				OFF_SEL_8_11: state_d.sel[11:8] = i_wdata[SEL_FIELD_W-1:0];
				OFF_SEL_12_15: state_d.sel[15:12] = i_wdata[SEL_FIELD_W-1:0];
				OFF_REMAP_2: state_d.addr_valid_pin_release = i_wdata[RELEASE_BIT];
				default: ;
			endcase
		end
		if (i_rd)
		begin
			// Reserved bits and unmapped offsets read zero
			case (i_addr)
				OFF_SEL_0_3: state_d.rdata[SEL_FIELD_W-1:0] = state_q.sel[3:0];
				OFF_SEL_4_7: state_d.rdata[SEL_FIELD_W-1:0] = state_q.sel[7:4];
				OFF_SEL_8_11: state_d.rdata[SEL_FIELD_W-1:0] = state_q.sel[11:8];
				OFF_SEL_12_15: state_d.rdata[SEL_FIELD_W-1:0] = state_q.sel[15:12];
				OFF_REMAP_2: state_d.rdata[RELEASE_BIT] = state_q.addr_valid_pin_release;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			state_q.sel <= {LINE_COUNT{SEL_RESET}};
			state_q.addr_valid_pin_release <= RELEASE_RESET;
			state_q.rdata <= RDATA_RESET;
			state_q.pins_meta <= '0;
			state_q.pins_sync <= '0;
			state_q.ext_line <= '0;
		end
		else
			state_q <= state_d;
	end

	assign o_rdata = state_q.rdata;
	assign o_ext_line = state_q.ext_line;
	assign o_addr_valid_pin_release = state_q.addr_valid_pin_release;
	// Strobe passes straight through so its timing to the memory bus is kept
	assign o_addr_valid_pin = state_q.addr_valid_pin_release ? 1'b0 : i_addr_valid_strobe;
	assign o_addr_valid_pin_oe = !state_q.addr_valid_pin_release;

	a_sel_low_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_SEL_0_3) |=> (state_q.sel[3:0] == $past(i_wdata[15:0])))
		else $error("Lines 0-3 selector write lost");

	a_sel_mid_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_rd && i_addr == OFF_SEL_4_7 && !i_wr) |=> (o_rdata == {16'h0000, $past(state_q.sel[7:4])}))
		else $error("Lines 4-7 readback wrong");

	a_sel_eight_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_SEL_8_11) ##1 (i_rd && i_addr == OFF_SEL_8_11)
		|=> (o_rdata[15:0] == $past(i_wdata[15:0], 2)))
		else $error("Lines 8-11 write then read mismatch");

	a_sel_high_resv: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$past(i_rd) && $past(i_addr) == OFF_SEL_12_15 |-> (o_rdata[31:16] == 16'h0000))
		else $error("Lines 12-15 reserved bits not zero");

	a_route_valid: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(state_q.sel[9] <= SEL_CODE_MAX && $stable(state_q.sel[9]))
		|=> (o_ext_line[9] == $past(state_q.pins_sync[state_q.sel[9][2:0]][9])))
		else $error("Line 9 not routed from selected port");

	a_route_resv: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(state_q.sel[5] > SEL_CODE_MAX) |=> !o_ext_line[5])
		else $error("Reserved code drove line 5");

	a_pin_release: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_REMAP_2 && i_wdata[10]) |=> !o_addr_valid_pin_oe)
		else $error("Address-valid pin still driven after release");

	a_pin_drive: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!o_addr_valid_pin_release |-> (o_addr_valid_pin_oe && o_addr_valid_pin == i_addr_valid_strobe))
		else $error("Address-valid strobe not on pin");

	a_release_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!(i_wr && i_addr == OFF_REMAP_2) |=> $stable(o_addr_valid_pin_release))
		else $error("Release bit changed without a write");

	// Write landing and readback for the remaining selector fields
	a_sel_mid_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_SEL_4_7)
		|=> (state_q.sel[7:4] == $past(i_wdata[15:0])))
		else $error("Lines 4-7 selector write lost");

	a_sel_third_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_SEL_8_11)
		|=> (state_q.sel[11:8] == $past(i_wdata[15:0])))
		else $error("Lines 8-11 selector write lost");

	a_sel_top_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_SEL_12_15)
		|=> (state_q.sel[15:12] == $past(i_wdata[15:0])))
		else $error("Lines 12-15 selector write lost");

	a_sel_low_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_rd && i_addr == OFF_SEL_0_3 && !i_wr)
		|=> (o_rdata == {16'h0000, $past(state_q.sel[3:0])}))
		else $error("Lines 0-3 readback wrong");

	a_sel_third_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_rd && i_addr == OFF_SEL_8_11 && !i_wr)
		|=> (o_rdata == {16'h0000, $past(state_q.sel[11:8])}))
		else $error("Lines 8-11 readback wrong");

	a_sel_top_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_rd && i_addr == OFF_SEL_12_15 && !i_wr)
		|=> (o_rdata == {16'h0000, $past(state_q.sel[15:12])}))
		else $error("Lines 12-15 readback wrong");

	// Selectors move only on a register write, never on their own
	a_sel_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_wr
		|=> $stable(state_q.sel))
		else $error("Selectors changed without a write");

	// Read data stands one cycle, then returns to zero
	a_rdata_idle: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_rd
		|=> (o_rdata == RDATA_RESET))
		else $error("Read data present without a read");

	a_remap_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_rd && i_addr == OFF_REMAP_2 && !i_wr)
		|=> (o_rdata == {21'h00_0000, $past(state_q.addr_valid_pin_release), 10'h000}))
		else $error("Release bit readback wrong");

	a_pin_reconnect: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_REMAP_2 && !i_wdata[RELEASE_BIT])
		|=> o_addr_valid_pin_oe)
		else $error("Address-valid pin not driven after reconnect");

	// Released pin also held low, so a stale strobe cannot leak out
	a_pin_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_addr_valid_pin_release
		|-> (!o_addr_valid_pin_oe && !o_addr_valid_pin))
		else $error("Released pin still carries the strobe");

	// Routing at both ends of the line range
	a_route_first: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(state_q.sel[0] <= SEL_CODE_MAX)
		|=> (o_ext_line[0] == $past(state_q.pins_sync[state_q.sel[0][2:0]][0])))
		else $error("Line 0 not routed from selected port");

	a_route_last: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(state_q.sel[15] <= SEL_CODE_MAX)
		|=> (o_ext_line[15] == $past(state_q.pins_sync[state_q.sel[15][2:0]][15])))
		else $error("Line 15 not routed from selected port");

	a_route_resv_top: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(state_q.sel[15] > SEL_CODE_MAX)
		|=> !o_ext_line[15])
		else $error("Reserved code drove line 15");

	// Main scenarios the bench should reach
	c_port_g: cover property (@(posedge i_clock) disable iff (!i_rstn)
		i_wr && i_addr == OFF_SEL_12_15 && i_wdata[3:0] == SEL_CODE_MAX);
	c_release: cover property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(o_addr_valid_pin_release));
	c_resv_code: cover property (@(posedge i_clock) disable iff (!i_rstn)
		state_q.sel[0] > SEL_CODE_MAX);
	c_back_to_back: cover property (@(posedge i_clock) disable iff (!i_rstn)
		(i_wr && i_addr == OFF_SEL_8_11) ##1 (i_rd && i_addr == OFF_SEL_8_11));
	c_reconnect: cover property (@(posedge i_clock) disable iff (!i_rstn)
		$fell(o_addr_valid_pin_release));
endmodule : els_top
`default_nettype wire

// file: shared/els_mux_if.sv
// Connection between the register core and the line source multiplexer
`timescale 1ns/1ps
`default_nettype none
interface els_mux_if;
	import els_pkg::*;
	logic [PORT_COUNT-1:0][LINE_COUNT-1:0] pins;
	logic [LINE_COUNT-1:0][SEL_W-1:0] sel;
	logic [LINE_COUNT-1:0] lines;
	modport ctrl (output pins, output sel, input lines);
	modport mux (input pins, input sel, output lines);
endinterface : els_mux_if
`default_nettype wire

// file: shared/els_pkg.sv
// Constants and state type for the external line source select block
package els_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LINE_COUNT = 16;
	localparam int unsigned PORT_COUNT = 7;
	localparam int unsigned SEL_W = 4;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_SEL_0_3 = 8'h08;
	localparam logic [7:0] OFF_SEL_4_7 = 8'h0C;
	localparam logic [7:0] OFF_SEL_8_11 = 8'h10;
	localparam logic [7:0] OFF_SEL_12_15 = 8'h14;
	localparam logic [7:0] OFF_REMAP_2 = 8'h1C;
	// Field positions
	localparam int unsigned SEL_FIELD_W = 16;
	localparam int unsigned RELEASE_BIT = 10;
	// Highest valid port code (port G)
	localparam logic [3:0] SEL_CODE_MAX = 4'h6;
	// Reset values
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic RELEASE_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [LINE_COUNT-1:0][SEL_W-1:0] sel;
		logic addr_valid_pin_release;
		logic [DATA_W-1:0] rdata;
		logic [PORT_COUNT-1:0][LINE_COUNT-1:0] pins_meta;
		logic [PORT_COUNT-1:0][LINE_COUNT-1:0] pins_sync;
		logic [LINE_COUNT-1:0] ext_line;
	} els_state_s;
endpackage : els_pkg

// file: sim/tb.sv
// Register, routing and pin release bench for the line source select block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import els_pkg::*;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [PORT_COUNT-1:0][LINE_COUNT-1:0] i_port_pins = '0;
	logic i_addr_valid_strobe = 1'b0;
	logic [DATA_W-1:0] o_rdata;
	logic [LINE_COUNT-1:0] o_ext_line;
	logic o_addr_valid_pin;
	logic o_addr_valid_pin_oe;
	logic o_addr_valid_pin_release;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [7:0] offs [4] = '{OFF_SEL_0_3, OFF_SEL_4_7, OFF_SEL_8_11, OFF_SEL_12_15};
	logic [15:0] e;
	always #50 i_clock = ~i_clock;
	els_top DUT (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_port_pins,
		.o_ext_line, .i_addr_valid_strobe, .o_addr_valid_pin, .o_addr_valid_pin_oe,
		.o_addr_valid_pin_release);
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x)
		begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, x);
	endtask : rd
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// Strobe toggles so a stuck pin output cannot match
	always @(posedge i_clock)
	begin
		i_addr_valid_strobe <= ~i_addr_valid_strobe;
		cycles++;
		if (cycles >= 2000)
		begin
			fail_count++;
			end_sim();
		end
	end
	initial
	begin
		for (int p = 0; p < 7; p++)
			i_port_pins[p] <= 16'hA5C3 ^ (16'h1357 * (p + 1));
		repeat (10) @(posedge i_clock);
		i_rstn <= 1'b1;
		for (int j = 0; j < 4; j++)
			rd(offs[j], 32'h0000_0000);
		rd(OFF_REMAP_2, 32'h0000_0000);
		chk(o_addr_valid_pin_oe, 1'b1);
		$display("Test reset values done");
		for (int j = 0; j < 4; j++)
			wr(offs[j], 32'hFFFF_6543 + j);
		for (int j = 0; j < 4; j++)
			rd(offs[j], 32'h0000_6543 + j);
		rd(8'h04, 32'h0000_0000);
		$display("Test register readback done");
		// Codes 7 and up are reserved and must route nothing
		for (int k = 0; k < 8; k++)
		begin
			for (int j = 0; j < 4; j++)
				wr(offs[j], {16'h0000, {4{k[3:0]}}});
			repeat (2) @(posedge i_clock);
			#1;
			e = (k < 7) ? i_port_pins[k] : 16'h0000;
			chk(o_ext_line, e);
		end
		$display("Test line routing done");
		for (int j = 0; j < 4; j++)
			wr(offs[j], 32'h0000_2222);
		repeat (2) @(posedge i_clock);
		e = i_port_pins[2];
		i_port_pins[2] <= ~e;
		repeat (2) @(posedge i_clock);
		#1 chk(o_ext_line, e);
		e = ~e;
		@(posedge i_clock);
		#1 chk(o_ext_line, e);
		@(posedge i_clock);
		i_addr <= OFF_SEL_8_11;
		i_wdata <= 32'h0000_2161;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, 32'h0000_2161);
		@(posedge i_clock);
		#1 chk(o_rdata, 32'h0000_0000);
		$display("Test pin latency and back-to-back access done");
		wr(OFF_REMAP_2, 32'hFFFF_FFFF);
		chk({o_addr_valid_pin_oe, o_addr_valid_pin, o_addr_valid_pin_release}, 3'b001);
		rd(OFF_REMAP_2, 32'h0000_0400);
		wr(OFF_REMAP_2, 32'hFFFF_FBFF);
		chk(o_addr_valid_pin_oe, 1'b1);
		chk(o_addr_valid_pin, i_addr_valid_strobe);
		@(posedge i_clock);
		#1 chk(o_addr_valid_pin, i_addr_valid_strobe);
		rd(OFF_REMAP_2, 32'h0000_0000);
		$display("Test pin release done");
		wr(OFF_REMAP_2, 32'h0000_0400);
		@(posedge i_clock);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rstn <= 1'b1;
		#1 chk({o_addr_valid_pin_oe, o_addr_valid_pin_release, o_ext_line}, 18'h2_0000);
		rd(OFF_SEL_12_15, 32'h0000_0000);
		$display("Test mid-run reset done");
		end_sim();
	end
endmodule : tb
`default_nettype wire
